// ===== mie_params.svh
// mie_params.svh: offsets, field positions, reset values and counts for the executor
// assumes: included by bare name from the executor module and the testbench
`ifndef MIE_PARAMS_SVH
`define MIE_PARAMS_SVH

// apb register byte offsets
`define MIE_OFS_CMD     8'h00
`define MIE_OFS_WORK    8'h04
`define MIE_OFS_FLAGS   8'h08
`define MIE_OFS_TPLOW   8'h0C
`define MIE_OFS_TPHIGH  8'h10
`define MIE_OFS_TLATCH  8'h14
`define MIE_OFS_SECT    8'h18
`define MIE_OFS_STATUS  8'h1C
`define MIE_OFS_DMADDR  8'h20
`define MIE_OFS_DMDATA  8'h24
`define MIE_OFS_PMADDR  8'h28
`define MIE_OFS_PMDATA  8'h2C

// status register bit positions
`define MIE_STAT_BUSY   0
`define MIE_STAT_SKIP   1
`define MIE_STAT_CYC_LO 2

// reset values
`define MIE_RST_BYTE    8'h00
`define MIE_RST_WORD    16'h0000

// decimal adjust constants
`define MIE_BCD_MAX     4'h9
`define MIE_ADJ_LOW     8'h06
`define MIE_ADJ_HIGH    8'h60

// cycle counts of an executed instruction
`define MIE_CYC_PLAIN   2'h1
`define MIE_CYC_SKIP    2'h2
`endif

// ===== mie_pkg.sv
// mie_pkg.sv: types shared by the instruction executor
// assumes: mie_params.svh holds the numeric constants
package mie_pkg;

  // operation codes; bit 5 marks the far (any section) forms
  typedef enum logic [5:0] {
    OP_NIBBLE_SWAP_TO_WORKING = 6'h01, OP_SKIP_ON_ZERO = 6'h02, OP_SKIP_ON_ZERO_LOAD = 6'h03,
    OP_SKIP_BIT_ZERO = 6'h04, OP_TABLE_READ_PAGE = 6'h05, OP_TABLE_READ_LAST_PAGE = 6'h06,
    OP_PREINC_TABLE_READ_PAGE = 6'h07, OP_PREINC_TABLE_READ_LAST = 6'h08,
    OP_XOR_TO_WORKING = 6'h09, OP_XOR_INTO_MEMORY = 6'h0A, OP_XOR_IMMEDIATE = 6'h0B,
    OP_FAR_ADD_CARRY = 6'h20, OP_FAR_ADD_CARRY_TO_MEM = 6'h21, OP_FAR_ADD = 6'h22,
    OP_FAR_ADD_TO_MEM = 6'h23, OP_FAR_BITWISE_AND = 6'h24, OP_FAR_BITWISE_AND_TO_MEM = 6'h25,
    OP_FAR_CLEAR = 6'h26, OP_FAR_CLEAR_BIT = 6'h27, OP_FAR_INVERT = 6'h28,
    OP_FAR_INVERT_TO_WORKING = 6'h29, OP_DECIMAL_ADJUST_TO_MEM = 6'h2A, OP_FAR_DECREMENT = 6'h2B,
    OP_FAR_DECREMENT_TO_WORKING = 6'h2C, OP_FAR_INCREMENT = 6'h2D,
    OP_FAR_INCREMENT_TO_WORKING = 6'h2E, OP_FAR_MOVE = 6'h2F
  } mie_op_t;

  // command word written to the command register
  typedef struct packed {
    logic [7:0] imm;
    logic [7:0] addr;
    logic [1:0] rsv_hi;
    logic [1:0] sect;
    logic       rsv_mid;
    logic [2:0] bit_sel;
    logic [1:0] rsv_lo;
    mie_op_t    op;
  } mie_cmd_t;

  // status flags, carry in bit 0
  typedef struct packed {
    logic signed_result_flag;
    logic signed_range_flag;
    logic zero;
    logic nibble_spill_flag;
    logic carry;
  } mie_flags_t;

  // executor sequencing, gray along idle-exec-dummy
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_DUMMY = 2'b11
  } mie_state_t;

endpackage

// ===== mie_exec.sv
// mie_exec.sv: instruction executor with data memory, program table and apb register slave
// assumes: apb master in the pclk domain; one clock; data and program memories are flip-flops
//
// What this block does
// (RL1) swap nibbles of memory into working register
// (RL2) zero memory byte skips next, two cycles
// (RL3) load byte to working, skip if zero
// (RL4) skip next when selected bit is zero
// (RL5) table read at high:low pointer into memory/latch
// (RL6) last-page table read uses low pointer only
// (RL7) increment low pointer, then page table read
// (RL8) increment low pointer, then last-page read
// (RL9) xor with memory or immediate, zero flag only
// (RL10) far forms reach any data memory section
// (RL11) far add with carry, five flags updated
// (RL12) far add without carry, five flags updated
// (RL13) far and, zero flag only
// (RL14) far clear byte or bit, no flags
// (RL15) far complement in place or to working
// (RL16) decimal adjust working into memory, carry only
// (RL17) far decrement in place or to working
// (RL18) far increment in place or to working
// (RL19) far move memory to working, no flags
// (RL20) zero flag set exactly when result zero
`timescale 1ns/1ps
`include "mie_params.svh"

module mie_exec #(
  parameter int DM_SECT_AW = 5,  // address bits within one data section
  parameter int DM_SECTS_W = 2,  // section select bits
  parameter int PM_AW      = 9   // program memory address bits
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  localparam int DM_AW = DM_SECT_AW + DM_SECTS_W;  // full data index width
  localparam int PM_PAGE_W = PM_AW - 8;             // page bits above the low pointer

  // zero test shared by every zero flag update and both zero skips
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);  // [RL20]
  endfunction

  // 8-bit add with carry in, returns {sc, ov, ac, c, sum}
  function automatic logic [11:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    logic       ov;
    s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    ov = (a[7] == b[7]) && (s[7] != a[7]);
    add8 = {ov ^ s[7], ov, h[4], s[8], s[7:0]};
  endfunction

  // architectural state
  logic [7:0]         work_reg;       // working_register
  mie_pkg::mie_flags_t flags_reg;     // status flags
  logic [7:0]         tplow_reg;      // table_pointer_low
  logic [7:0]         tphigh_reg;     // table_pointer_high
  logic [7:0]         tlatch_reg;     // table_read_high_latch
  logic [DM_SECTS_W-1:0] sect_reg;    // currently selected section
  mie_pkg::mie_cmd_t  cmd_reg;        // command being executed
  mie_pkg::mie_state_t state_reg;     // sequencer
  logic               skip_reg;       // last instruction skipped
  logic [1:0]         cyc_reg;        // cycles of last instruction
  logic [DM_AW-1:0]   dmaddr_reg;     // software window into data memory
  logic [PM_AW-1:0]   pmaddr_reg;     // software window into program memory
  logic [7:0]         dm_mem [2**DM_AW];   // data memory
  logic [15:0]        pm_mem [2**PM_AW];   // program memory
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;

  // apb decode
  wire apb_access = psel && penable;
  wire apb_done   = apb_access && pready_reg;
  wire wr_go      = apb_done && pwrite;
  wire is_cmd     = (paddr == `MIE_OFS_CMD);
  wire busy       = (state_reg != mie_pkg::ST_IDLE);
  wire hit_cmd    = wr_go && is_cmd;
  wire addr_known = (paddr[1:0] == 2'b00) && (paddr <= `MIE_OFS_PMDATA);

  // operand addressing: far forms take the section from the command
  wire               is_far  = cmd_reg.op[5];
  wire [DM_SECTS_W-1:0] op_sect = is_far ? cmd_reg.sect[DM_SECTS_W-1:0] : sect_reg;  // [RL10]
  wire [DM_AW-1:0]   op_idx  = {op_sect, cmd_reg.addr[DM_SECT_AW-1:0]};
  wire [7:0]         mem_b   = dm_mem[op_idx];
  wire               sel_bit = mem_b[cmd_reg.bit_sel];

  // table pointer, pre-incremented for the increment forms
  wire               tbl_inc  = (cmd_reg.op == mie_pkg::OP_PREINC_TABLE_READ_PAGE) ||
                                (cmd_reg.op == mie_pkg::OP_PREINC_TABLE_READ_LAST);
  wire               tbl_last = (cmd_reg.op == mie_pkg::OP_TABLE_READ_LAST_PAGE) ||
                                (cmd_reg.op == mie_pkg::OP_PREINC_TABLE_READ_LAST);
  wire [7:0]         tp_low   = tbl_inc ? 8'(tplow_reg + 8'h01) : tplow_reg;  // [RL7] [RL8]
  wire [PM_PAGE_W-1:0] tp_page = tbl_last ? {PM_PAGE_W{1'b1}} : tphigh_reg[PM_PAGE_W-1:0];  // [RL6]
  wire [15:0]        pm_word  = pm_mem[{tp_page, tp_low}];  // [RL5]

  // arithmetic results
  wire [11:0] add_c  = add8(work_reg, mem_b, flags_reg.carry);  // [RL11]
  wire [11:0] add_n  = add8(work_reg, mem_b, 1'b0);              // [RL12]
  wire        adj_lo = (work_reg[3:0] > `MIE_BCD_MAX) || flags_reg.nibble_spill_flag;
  wire        adj_hi = (work_reg[7:4] > `MIE_BCD_MAX) || flags_reg.carry;
  wire [8:0]  daa_s  = {1'b0, work_reg} + {1'b0, (adj_lo ? `MIE_ADJ_LOW : 8'h00)}
                     + {1'b0, (adj_hi ? `MIE_ADJ_HIGH : 8'h00)};  // [RL16]

  // execution result selection
  logic [7:0]          res;
  logic                wr_mem;
  logic                wr_work;
  logic                wr_tbl;
  logic                skip_now;
  mie_pkg::mie_flags_t flags_n;
  always_comb begin
    res      = mem_b;
    wr_mem   = 1'b0;
    wr_work  = 1'b0;
    wr_tbl   = 1'b0;
    skip_now = 1'b0;
    flags_n  = flags_reg;
    unique case (cmd_reg.op)
      mie_pkg::OP_NIBBLE_SWAP_TO_WORKING: begin
        res     = {mem_b[3:0], mem_b[7:4]};  // [RL1]
        wr_work = 1'b1;
      end
      mie_pkg::OP_SKIP_ON_ZERO: begin
        skip_now = is_zero(mem_b);  // [RL2]
      end
      mie_pkg::OP_SKIP_ON_ZERO_LOAD: begin
        wr_work  = 1'b1;  // [RL3]
        skip_now = is_zero(mem_b);
      end
      mie_pkg::OP_SKIP_BIT_ZERO: begin
        skip_now = !sel_bit;  // [RL4]
      end
      mie_pkg::OP_TABLE_READ_PAGE, mie_pkg::OP_TABLE_READ_LAST_PAGE,
      mie_pkg::OP_PREINC_TABLE_READ_PAGE, mie_pkg::OP_PREINC_TABLE_READ_LAST: begin
        res    = pm_word[7:0];  // [RL5] [RL6] [RL7] [RL8]
        wr_mem = 1'b1;
        wr_tbl = 1'b1;
      end
      mie_pkg::OP_XOR_TO_WORKING, mie_pkg::OP_XOR_INTO_MEMORY, mie_pkg::OP_XOR_IMMEDIATE: begin
        res = work_reg ^ ((cmd_reg.op == mie_pkg::OP_XOR_IMMEDIATE) ? cmd_reg.imm : mem_b);  // [RL9]
        wr_mem       = (cmd_reg.op == mie_pkg::OP_XOR_INTO_MEMORY);
        wr_work      = !wr_mem;
        flags_n.zero = is_zero(res);
      end
      mie_pkg::OP_FAR_ADD_CARRY, mie_pkg::OP_FAR_ADD_CARRY_TO_MEM: begin
        {flags_n.signed_result_flag, flags_n.signed_range_flag, flags_n.nibble_spill_flag,
         flags_n.carry, res} = add_c;  // [RL11]
        flags_n.zero = is_zero(res);
        wr_mem       = (cmd_reg.op == mie_pkg::OP_FAR_ADD_CARRY_TO_MEM);
        wr_work      = !wr_mem;
      end
      mie_pkg::OP_FAR_ADD, mie_pkg::OP_FAR_ADD_TO_MEM: begin
        {flags_n.signed_result_flag, flags_n.signed_range_flag, flags_n.nibble_spill_flag,
         flags_n.carry, res} = add_n;  // [RL12]
        flags_n.zero = is_zero(res);
        wr_mem       = (cmd_reg.op == mie_pkg::OP_FAR_ADD_TO_MEM);
        wr_work      = !wr_mem;
      end
      mie_pkg::OP_FAR_BITWISE_AND, mie_pkg::OP_FAR_BITWISE_AND_TO_MEM: begin
        res          = work_reg & mem_b;  // [RL13]
        flags_n.zero = is_zero(res);
        wr_mem       = (cmd_reg.op == mie_pkg::OP_FAR_BITWISE_AND_TO_MEM);
        wr_work      = !wr_mem;
      end
      mie_pkg::OP_FAR_CLEAR: begin
        res    = 8'h00;  // [RL14]
        wr_mem = 1'b1;
      end
      mie_pkg::OP_FAR_CLEAR_BIT: begin
        res    = mem_b & ~(8'h01 << cmd_reg.bit_sel);  // [RL14]
        wr_mem = 1'b1;
      end
      mie_pkg::OP_FAR_INVERT, mie_pkg::OP_FAR_INVERT_TO_WORKING: begin
        res          = ~mem_b;  // [RL15]
        flags_n.zero = is_zero(res);
        wr_work      = (cmd_reg.op == mie_pkg::OP_FAR_INVERT_TO_WORKING);
        wr_mem       = !wr_work;
      end
      mie_pkg::OP_DECIMAL_ADJUST_TO_MEM: begin
        res           = daa_s[7:0];  // [RL16]
        flags_n.carry = flags_reg.carry || daa_s[8];
        wr_mem        = 1'b1;
      end
      mie_pkg::OP_FAR_DECREMENT, mie_pkg::OP_FAR_DECREMENT_TO_WORKING: begin
        res          = 8'(mem_b - 8'h01);  // [RL17]
        flags_n.zero = is_zero(res);
        wr_work      = (cmd_reg.op == mie_pkg::OP_FAR_DECREMENT_TO_WORKING);
        wr_mem       = !wr_work;
      end
      mie_pkg::OP_FAR_INCREMENT, mie_pkg::OP_FAR_INCREMENT_TO_WORKING: begin
        res          = 8'(mem_b + 8'h01);  // [RL18]
        flags_n.zero = is_zero(res);
        wr_work      = (cmd_reg.op == mie_pkg::OP_FAR_INCREMENT_TO_WORKING);
        wr_mem       = !wr_work;
      end
      mie_pkg::OP_FAR_MOVE: begin
        wr_work = 1'b1;  // [RL19]
      end
      default: begin
        // undefined code: no state changes
      end
    endcase
  end

  wire executing = (state_reg == mie_pkg::ST_EXEC);

  // sequencer: exec one cycle, dummy cycle only when skipping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= mie_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        mie_pkg::ST_IDLE:  state_reg <= hit_cmd ? mie_pkg::ST_EXEC : mie_pkg::ST_IDLE;
        mie_pkg::ST_EXEC:  state_reg <= skip_now ? mie_pkg::ST_DUMMY : mie_pkg::ST_IDLE;  // [RL2]
        mie_pkg::ST_DUMMY: state_reg <= mie_pkg::ST_IDLE;
        default:           state_reg <= mie_pkg::ST_IDLE;
      endcase
    end
  end

  // command capture and last-instruction report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg  <= '0;
      skip_reg <= 1'b0;
      cyc_reg  <= 2'h0;
    end else if (hit_cmd) begin
      cmd_reg <= mie_mie_cmd(pwdata);
    end else if (executing) begin
      skip_reg <= skip_now;
      cyc_reg  <= skip_now ? `MIE_CYC_SKIP : `MIE_CYC_PLAIN;  // [RL2]
    end
  end

  function automatic mie_pkg::mie_cmd_t mie_mie_cmd(input logic [31:0] w);
    mie_mie_cmd = mie_pkg::mie_cmd_t'(w);
  endfunction

  // working register, flags, table latch and pointers; execution wins over software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_reg   <= `MIE_RST_BYTE;
      flags_reg  <= '0;
      tlatch_reg <= `MIE_RST_BYTE;
      tplow_reg  <= `MIE_RST_BYTE;
      tphigh_reg <= `MIE_RST_BYTE;
      sect_reg   <= '0;
    end else if (executing) begin
      if (wr_work) work_reg <= res;
      flags_reg <= flags_n;  // [RL20]
      if (wr_tbl) tlatch_reg <= pm_word[15:8];  // [RL5] [RL6]
      if (tbl_inc) tplow_reg <= tp_low;  // [RL7] [RL8]
    end else if (wr_go) begin
      if (paddr == `MIE_OFS_WORK) work_reg <= pwdata[7:0];
      if (paddr == `MIE_OFS_FLAGS) flags_reg <= mie_pkg::mie_flags_t'(pwdata[4:0]);
      if (paddr == `MIE_OFS_TPLOW) tplow_reg <= pwdata[7:0];
      if (paddr == `MIE_OFS_TPHIGH) tphigh_reg <= pwdata[7:0];
      if (paddr == `MIE_OFS_SECT) sect_reg <= pwdata[DM_SECTS_W-1:0];
    end
  end

  // memory windows and storage; memories hold no reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dmaddr_reg <= '0;
      pmaddr_reg <= '0;
    end else if (wr_go) begin
      if (paddr == `MIE_OFS_DMADDR) dmaddr_reg <= pwdata[DM_AW-1:0];
      if (paddr == `MIE_OFS_PMADDR) pmaddr_reg <= pwdata[PM_AW-1:0];
    end
  end

  always_ff @(posedge pclk) begin
    if (executing && wr_mem) begin
      dm_mem[op_idx] <= res;
    end else if (wr_go && paddr == `MIE_OFS_DMDATA) begin
      dm_mem[dmaddr_reg] <= pwdata[7:0];
    end
    if (wr_go && paddr == `MIE_OFS_PMDATA) begin
      pm_mem[pmaddr_reg] <= pwdata[15:0];
    end
  end

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `MIE_OFS_CMD:    rd_mux = cmd_reg;
      `MIE_OFS_WORK:   rd_mux = {24'h00_0000, work_reg};
      `MIE_OFS_FLAGS:  rd_mux = {27'h000_0000, flags_reg};
      `MIE_OFS_TPLOW:  rd_mux = {24'h00_0000, tplow_reg};
      `MIE_OFS_TPHIGH: rd_mux = {24'h00_0000, tphigh_reg};
      `MIE_OFS_TLATCH: rd_mux = {24'h00_0000, tlatch_reg};
      `MIE_OFS_SECT:   rd_mux = 32'(sect_reg);
      `MIE_OFS_STATUS: rd_mux = {28'h000_0000, cyc_reg, skip_reg, busy};
      `MIE_OFS_DMADDR: rd_mux = 32'(dmaddr_reg);
      `MIE_OFS_DMDATA: rd_mux = {24'h00_0000, dm_mem[dmaddr_reg]};
      `MIE_OFS_PMADDR: rd_mux = 32'(pmaddr_reg);
      `MIE_OFS_PMDATA: rd_mux = {16'h0000, pm_mem[pmaddr_reg]};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait state, held off while an instruction runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_access && !pready_reg && !busy;
      pslverr_reg <= apb_access && !pready_reg && !busy && !addr_known;
      if (apb_access && !pready_reg && !busy) prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence exec_of(mie_pkg::mie_op_t o);
    executing && cmd_reg.op == o;
  endsequence
  sequence dummy_then_idle;
    state_reg == mie_pkg::ST_DUMMY ##1 state_reg == mie_pkg::ST_IDLE;
  endsequence

  swap_to_work_a: assert property (exec_of(mie_pkg::OP_NIBBLE_SWAP_TO_WORKING) |=>  // [RL1]
    work_reg == {$past(mem_b[3:0]), $past(mem_b[7:4])} && flags_reg == $past(flags_reg))
    else $error("nibble swap result wrong");
  zero_skip_a: assert property (executing && cmd_reg.op == mie_pkg::OP_SKIP_ON_ZERO && mem_b == 8'h00  // [RL2]
    |=> dummy_then_idle) else $error("zero skip lacks dummy cycle");
  load_skip_a: assert property (exec_of(mie_pkg::OP_SKIP_ON_ZERO_LOAD)  // [RL3]
    |=> work_reg == $past(mem_b) && skip_reg == ($past(mem_b) == 8'h00)) else $error("load skip wrong");
  bit_skip_a: assert property (executing && cmd_reg.op == mie_pkg::OP_SKIP_BIT_ZERO && sel_bit  // [RL4]
    |=> state_reg == mie_pkg::ST_IDLE && !skip_reg) else $error("bit set must not skip");
  table_latch_a: assert property (executing && wr_tbl  // [RL5]
    |=> tlatch_reg == $past(pm_word[15:8]) && dm_mem[$past(op_idx)] == $past(pm_word[7:0]))
    else $error("table read store wrong");
  preinc_ptr_a: assert property (executing && tbl_inc |=> tplow_reg == 8'($past(tplow_reg) + 8'h01))  // [RL7]
    else $error("pointer not incremented");
  xor_flags_a: assert property (exec_of(mie_pkg::OP_XOR_IMMEDIATE) |=>  // [RL9]
    flags_reg.zero == ($past(work_reg ^ cmd_reg.imm) == 8'h00) && flags_reg.carry == $past(flags_reg.carry))
    else $error("xor flag update wrong");
  add_carry_a: assert property (exec_of(mie_pkg::OP_FAR_ADD_CARRY)  // [RL11]
    |=> {flags_reg.carry, work_reg} == 9'($past(work_reg) + $past(mem_b) + $past(flags_reg.carry)))
    else $error("add with carry wrong");
  clear_flags_a: assert property (exec_of(mie_pkg::OP_FAR_CLEAR)  // [RL14]
    |=> dm_mem[$past(op_idx)] == 8'h00 && $stable(flags_reg)) else $error("clear wrong");
  move_work_a: assert property (exec_of(mie_pkg::OP_FAR_MOVE)  // [RL19]
    |=> work_reg == $past(mem_b) && $stable(flags_reg)) else $error("move wrong");

endmodule

// ===== mie_exec_tb.sv
// mie_exec_tb.sv: self-checking bench for the instruction executor, driven over apb
// assumes: mie_pkg and mie_exec are compiled first; the bench is the only apb master
`timescale 1ns/1ps
`include "mie_params.svh"

module mie_exec_tb;
  // clock, reset and apb master signals
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // bookkeeping
  int          err_total;    // mismatches seen
  int          n_compared;   // comparisons made
  int          cyc_cnt = 0;  // cycles since start, for the hang limit
  logic [31:0] rd_data;      // data of the last transfer
  logic        rd_err;       // error flag of the last transfer
  // register byte offsets
  localparam logic [7:0] A_WK = `MIE_OFS_WORK;
  localparam logic [7:0] A_FL = `MIE_OFS_FLAGS;
  localparam logic [7:0] A_TL = `MIE_OFS_TPLOW;
  localparam logic [7:0] A_LT = `MIE_OFS_TLATCH;
  localparam logic [7:0] A_ST = `MIE_OFS_STATUS;

  mie_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // free-running clock, 25 ns period
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // hang limit: far above the several hundred cycles the tests need
  always @(posedge pclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total = err_total + 1;
      summarize();
    end
  end

  // print counts and the verdict, then stop
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one comparison; unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge; waits while the executor is busy
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // register write, and register read against an expected value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_data, exp);
  endtask

  // data memory byte at {section, address}: set and check
  task automatic setm(input logic [1:0] s, input logic [4:0] a, input logic [7:0] v);
    wr(`MIE_OFS_DMADDR, {25'h0, s, a});
    wr(`MIE_OFS_DMDATA, {24'h0, v});
  endtask
  task automatic chkm(input logic [1:0] s, input logic [4:0] a, input logic [7:0] v);
    wr(`MIE_OFS_DMADDR, {25'h0, s, a});
    rc(`MIE_OFS_DMDATA, {24'h0, v});
  endtask

  // preset working register and flags
  task automatic pre(input logic [7:0] w, input logic [4:0] f);
    wr(A_WK, {24'h0, w});
    wr(A_FL, {27'h0, f});
  endtask

  // issue one instruction through the command register
  task automatic run(input mie_pkg::mie_op_t op, input logic [1:0] s, input logic [4:0] a,
                     input logic [2:0] b, input logic [7:0] imm);
    wr(`MIE_OFS_CMD, {imm, 3'h0, a, 2'h0, s, 1'h0, b, 2'h0, op});
  endtask

  // skip test at section 0, then status: 0A skipped in two cycles, 04 plain
  task automatic skp(input mie_pkg::mie_op_t op, input logic [4:0] a, input logic [2:0] b,
                     input logic [31:0] st);
    run(op, 2'h0, a, b, 8'h00);
    rc(A_ST, st);
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    err_total  = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // registers from working to status read zero after reset
    for (int i = 1; i < 8; i++) rc(8'(i * 4), 32'h0);
    // unmapped address answers with an error and zero data
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    chk(rd_data, 32'h0);
    // nibble swap into working, memory and flags kept
    setm(2'h0, 5'h01, 8'h3C);
    pre(8'h00, 5'h1B);
    run(mie_pkg::OP_NIBBLE_SWAP_TO_WORKING, 2'h0, 5'h01, 3'h0, 8'h00);
    rc(A_WK, 32'hC3);
    rc(A_FL, 32'h1B);
    chkm(2'h0, 5'h01, 8'h3C);
    // skip tests on zero and non-zero bytes and bits
    setm(2'h0, 5'h02, 8'h00);
    setm(2'h0, 5'h03, 8'h80);
    skp(mie_pkg::OP_SKIP_ON_ZERO, 5'h02, 3'h0, 32'h0A);
    skp(mie_pkg::OP_SKIP_ON_ZERO, 5'h03, 3'h0, 32'h04);
    skp(mie_pkg::OP_SKIP_ON_ZERO_LOAD, 5'h02, 3'h0, 32'h0A);
    rc(A_WK, 32'h00);
    skp(mie_pkg::OP_SKIP_ON_ZERO_LOAD, 5'h03, 3'h0, 32'h04);
    rc(A_WK, 32'h80);
    rc(A_FL, 32'h1B);
    skp(mie_pkg::OP_SKIP_BIT_ZERO, 5'h03, 3'h6, 32'h0A);
    skp(mie_pkg::OP_SKIP_BIT_ZERO, 5'h03, 3'h7, 32'h04);
    // table reads: page word at 012, last page word at 112
    wr(`MIE_OFS_PMADDR, 32'h012);
    wr(`MIE_OFS_PMDATA, 32'hABCD);
    wr(`MIE_OFS_PMADDR, 32'h112);
    wr(`MIE_OFS_PMDATA, 32'h1234);
    wr(A_TL, 32'h12);
    wr(`MIE_OFS_TPHIGH, 32'h00);
    run(mie_pkg::OP_TABLE_READ_PAGE, 2'h0, 5'h04, 3'h0, 8'h00);
    chkm(2'h0, 5'h04, 8'hCD);
    rc(A_LT, 32'hAB);
    run(mie_pkg::OP_TABLE_READ_LAST_PAGE, 2'h0, 5'h05, 3'h0, 8'h00);
    chkm(2'h0, 5'h05, 8'h34);
    rc(A_LT, 32'h12);
    // latch is read-only
    wr(A_LT, 32'hFF);
    rc(A_LT, 32'h12);
    wr(A_TL, 32'h11);
    run(mie_pkg::OP_PREINC_TABLE_READ_PAGE, 2'h0, 5'h06, 3'h0, 8'h00);
    chkm(2'h0, 5'h06, 8'hCD);
    rc(A_TL, 32'h12);
    wr(A_TL, 32'h11);
    run(mie_pkg::OP_PREINC_TABLE_READ_LAST, 2'h0, 5'h07, 3'h0, 8'h00);
    chkm(2'h0, 5'h07, 8'h34);
    rc(A_LT, 32'h12);
    rc(A_TL, 32'h12);
    // exclusive-or: zero result sets zero, others clear it
    setm(2'h0, 5'h08, 8'h0F);
    pre(8'h0F, 5'h00);
    run(mie_pkg::OP_XOR_TO_WORKING, 2'h0, 5'h08, 3'h0, 8'h00);
    rc(A_WK, 32'h00);
    rc(A_FL, 32'h04);
    run(mie_pkg::OP_XOR_IMMEDIATE, 2'h0, 5'h08, 3'h0, 8'h5A);
    rc(A_WK, 32'h5A);
    run(mie_pkg::OP_XOR_INTO_MEMORY, 2'h0, 5'h08, 3'h0, 8'h00);
    chkm(2'h0, 5'h08, 8'h55);
    rc(A_FL, 32'h00);
    // far move from section 3 while current section is 0
    setm(2'h3, 5'h09, 8'h77);
    setm(2'h0, 5'h09, 8'h11);
    pre(8'h00, 5'h1B);
    run(mie_pkg::OP_FAR_MOVE, 2'h3, 5'h09, 3'h0, 8'h00);
    rc(A_WK, 32'h77);
    rc(A_FL, 32'h1B);
    // add with carry: 7F+00+1 overflows into the sign
    setm(2'h3, 5'h0A, 8'h00);
    pre(8'h7F, 5'h01);
    run(mie_pkg::OP_FAR_ADD_CARRY, 2'h3, 5'h0A, 3'h0, 8'h00);
    rc(A_WK, 32'h80);
    rc(A_FL, 32'h0A);
    run(mie_pkg::OP_FAR_ADD_CARRY_TO_MEM, 2'h3, 5'h0A, 3'h0, 8'h00);
    chkm(2'h3, 5'h0A, 8'h80);
    rc(A_FL, 32'h10);
    // add ignores carry in: FF+01 wraps to zero
    setm(2'h3, 5'h0B, 8'h01);
    pre(8'hFF, 5'h01);
    run(mie_pkg::OP_FAR_ADD, 2'h3, 5'h0B, 3'h0, 8'h00);
    rc(A_WK, 32'h00);
    rc(A_FL, 32'h07);
    run(mie_pkg::OP_FAR_ADD_TO_MEM, 2'h3, 5'h0B, 3'h0, 8'h00);
    chkm(2'h3, 5'h0B, 8'h01);
    rc(A_FL, 32'h00);
    // and: only zero flag follows the result
    setm(2'h3, 5'h0C, 8'h3C);
    setm(2'h3, 5'h0D, 8'h0F);
    pre(8'hF0, 5'h1F);
    run(mie_pkg::OP_FAR_BITWISE_AND, 2'h3, 5'h0C, 3'h0, 8'h00);
    rc(A_WK, 32'h30);
    rc(A_FL, 32'h1B);
    run(mie_pkg::OP_FAR_BITWISE_AND_TO_MEM, 2'h3, 5'h0D, 3'h0, 8'h00);
    chkm(2'h3, 5'h0D, 8'h00);
    rc(A_FL, 32'h1F);
    // clear byte and bit, flags kept
    setm(2'h3, 5'h0E, 8'hFF);
    wr(A_FL, 32'h1B);
    run(mie_pkg::OP_FAR_CLEAR, 2'h3, 5'h0E, 3'h0, 8'h00);
    chkm(2'h3, 5'h0E, 8'h00);
    setm(2'h3, 5'h0E, 8'hFF);
    run(mie_pkg::OP_FAR_CLEAR_BIT, 2'h3, 5'h0E, 3'h4, 8'h00);
    chkm(2'h3, 5'h0E, 8'hEF);
    rc(A_FL, 32'h1B);
    // complement in place, then to working
    run(mie_pkg::OP_FAR_INVERT, 2'h3, 5'h0E, 3'h0, 8'h00);
    chkm(2'h3, 5'h0E, 8'h10);
    setm(2'h3, 5'h0F, 8'hFF);
    run(mie_pkg::OP_FAR_INVERT, 2'h3, 5'h0F, 3'h0, 8'h00);
    rc(A_FL, 32'h1F);
    run(mie_pkg::OP_FAR_INVERT_TO_WORKING, 2'h3, 5'h0F, 3'h0, 8'h00);
    rc(A_WK, 32'hFF);
    chkm(2'h3, 5'h0F, 8'h00);
    rc(A_FL, 32'h1B);
    // decimal adjust: high nibble above 9 sets carry; spill adds 6
    pre(8'hA5, 5'h00);
    run(mie_pkg::OP_DECIMAL_ADJUST_TO_MEM, 2'h3, 5'h10, 3'h0, 8'h00);
    chkm(2'h3, 5'h10, 8'h05);
    rc(A_FL, 32'h01);
    pre(8'h12, 5'h02);
    run(mie_pkg::OP_DECIMAL_ADJUST_TO_MEM, 2'h3, 5'h10, 3'h0, 8'h00);
    chkm(2'h3, 5'h10, 8'h18);
    rc(A_FL, 32'h02);
    // decrement and increment, in place and to working
    setm(2'h3, 5'h11, 8'h01);
    pre(8'h00, 5'h00);
    run(mie_pkg::OP_FAR_DECREMENT, 2'h3, 5'h11, 3'h0, 8'h00);
    chkm(2'h3, 5'h11, 8'h00);
    rc(A_FL, 32'h04);
    run(mie_pkg::OP_FAR_DECREMENT_TO_WORKING, 2'h3, 5'h11, 3'h0, 8'h00);
    rc(A_WK, 32'hFF);
    chkm(2'h3, 5'h11, 8'h00);
    setm(2'h3, 5'h12, 8'hFF);
    run(mie_pkg::OP_FAR_INCREMENT, 2'h3, 5'h12, 3'h0, 8'h00);
    chkm(2'h3, 5'h12, 8'h00);
    rc(A_FL, 32'h04);
    run(mie_pkg::OP_FAR_INCREMENT_TO_WORKING, 2'h3, 5'h12, 3'h0, 8'h00);
    rc(A_WK, 32'h01);
    chkm(2'h3, 5'h12, 8'h00);
    rc(A_FL, 32'h00);
    summarize();
  end
endmodule
